// ===== trap_wake_pkg.sv
package trap_wake_pkg;

  // wake port geometry
  localparam int unsigned WAKE_LINES = 8;

  // register offsets on the plain register port
  localparam logic [1:0] ADDR_WAKE_EN   = 2'h0;
  localparam logic [1:0] ADDR_WAKE_EDGE = 2'h1;
  localparam logic [1:0] ADDR_WAKE_PEND = 2'h2;
  localparam logic [1:0] ADDR_IRQ_CTRL  = 2'h3;

  // control register field positions
  localparam int unsigned CTRL_GROUP_EN_BIT  = 0;
  localparam int unsigned CTRL_GLOBAL_EN_BIT = 1;
  localparam int unsigned CTRL_WAKE_REQ_BIT  = 2;

  // reset values
  localparam logic [7:0] WAKE_EN_RST   = 8'h00;
  localparam logic [7:0] WAKE_EDGE_RST = 8'h00;
  localparam logic [7:0] WAKE_PEND_RST = 8'h00;
  localparam logic [7:0] RDATA_RST     = 8'h00;

  // opcode and vector low bytes
  localparam logic [7:0] TRAP_OPCODE     = 8'h00;
  localparam logic [7:0] ZERO_FETCH_BYTE = 8'h00;
  localparam logic [7:0] VEC_LO_TRAP     = 8'hFE;
  localparam logic [7:0] VEC_LO_WAKE     = 8'hE2;
  localparam logic [7:0] VEC_LO_DEFAULT  = 8'hE0;

  // stack pop limits for the two ram sizes
  localparam logic [7:0] STACK_LIMIT_SMALL = 8'h2F;
  localparam logic [7:0] STACK_LIMIT_LARGE = 8'h6F;

  // one instruction fetch as seen by the interrupt logic
  typedef struct packed {
    logic        valid;     // byte loaded into the instruction register
    logic        unmapped;  // address beyond implemented program memory
    logic [14:0] pc;        // address of the fetched byte
    logic [7:0]  data;      // raw byte from program memory
  } fetch_t;

  // stack pop event
  typedef struct packed {
    logic       pop;        // stack pointer incremented by a pop
    logic [7:0] sp_after;   // stack pointer value after the pop
    logic       large_ram;  // selects the larger ram limit
  } stack_pop_t;

endpackage

// ===== trap_wake_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module trap_wake_irq_ctrl
  import trap_wake_pkg::*;
#(
  parameter int unsigned N_LINES = WAKE_LINES
)(
  input  wire logic               i_mclk,
  input  wire logic               i_nrst,
  // register port
  input  wire logic [1:0]         i_addr,
  input  wire logic [7:0]         i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [7:0]         o_rdata,
  // core sequencer side
  input  wire fetch_t             i_fetch,
  input  wire stack_pop_t         i_stack,
  input  wire logic               i_clear_trap_pending_op,
  input  wire logic               i_vector_dispatch_op,
  input  wire logic               i_maskable_isr_active,
  input  wire logic               i_halted,
  output logic      [7:0]         o_fetch_opcode,
  output logic                    o_trap_raise,
  output logic      [14:0]        o_trap_return_pc,
  output logic                    o_trap_req,
  output logic                    o_maskable_req,
  output logic      [7:0]         o_vector_lo,
  output logic                    o_wake,
  output logic                    o_wake_service,
  // wake port pins
  input  wire logic [N_LINES-1:0] i_wake_pins
);

  // fetch path: missing memory reads back as zero
  logic fetch_is_trap;  // opcode decode hit
  logic stack_overpop;  // pop beyond ram limit
  logic trap_event;     // any trap cause this cycle
  logic [7:0] limit;    // active stack limit

  always_comb
  begin
    // unmapped locations force zeros into the instruction register
    o_fetch_opcode = i_fetch.unmapped ? ZERO_FETCH_BYTE : i_fetch.data;
    // trap is raised on the fetch itself, not later in execution
    fetch_is_trap  = i_fetch.valid && (o_fetch_opcode == TRAP_OPCODE);
    limit          = i_stack.large_ram ? STACK_LIMIT_LARGE : STACK_LIMIT_SMALL;
    // sp above the limit after a pop means the stack underflowed
    stack_overpop  = i_stack.pop && (i_stack.sp_after > limit);
    trap_event     = fetch_is_trap || stack_overpop;
  end

  // trap pending flag: internal only, no register address reaches it
  logic        trap_pending_flag_q;  // hidden pending bit
  logic        trap_pending_flag_d;
  logic        trap_raise_q;         // one-cycle raise pulse
  logic        trap_raise_d;
  logic [14:0] trap_pc_q;            // address of trapping instruction
  logic [14:0] trap_pc_d;

  // next state of the trap group
  always_comb
  begin
    trap_pending_flag_d = trap_pending_flag_q;
    // clear is unconditional and harmless when already clear
    if (i_clear_trap_pending_op)
    begin
      trap_pending_flag_d = 1'b0;
    end
    // a trap in the clearing cycle must not be lost, so set wins
    if (trap_event)
    begin
      trap_pending_flag_d = 1'b1;
    end
    trap_raise_d = trap_event;
    trap_pc_d    = trap_pc_q;
    // return to the trap opcode itself, software must skip it
    if (trap_event)
    begin
      trap_pc_d = i_fetch.pc;
    end
  end

  // trap group registers
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      trap_pending_flag_q <= 1'b0;
      trap_raise_q        <= 1'b0;
      trap_pc_q           <= 15'h0000;
    end
    else
    begin
      trap_pending_flag_q <= trap_pending_flag_d;
      trap_raise_q        <= trap_raise_d;
      trap_pc_q           <= trap_pc_d;
    end
  end

  assign o_trap_raise     = trap_raise_q;
  assign o_trap_return_pc = trap_pc_q;
  // no enable gates the trap, and a new trap may nest inside its routine
  assign o_trap_req       = trap_pending_flag_q;

  // wake port registers
  logic [N_LINES-1:0] wake_line_enable_mask_q;  // per-line enables
  logic [N_LINES-1:0] wake_line_enable_mask_d;
  logic [N_LINES-1:0] wake_line_edge_select_q;  // 0 rising, 1 falling
  logic [N_LINES-1:0] wake_line_edge_select_d;
  logic [N_LINES-1:0] wake_line_pending_q;      // latched triggers
  logic [N_LINES-1:0] wake_line_pending_d;
  logic [N_LINES-1:0] pins_prev_q;              // last sampled pins
  logic               wake_port_group_enable_q; // port-wide enable
  logic               wake_port_group_enable_d;
  logic               global_irq_enable_q;      // core-wide enable
  logic               global_irq_enable_d;
  logic [N_LINES-1:0] edge_hit;                 // trigger per line
  logic               wake_req;                 // arbiter request
  logic               any_armed;                // pending and enabled

  // per-line edge detectors
  genvar g;
  generate
    for (g = 0; g < N_LINES; g++)
    begin : g_edge
      // each line picks its own polarity
      assign edge_hit[g] = wake_line_edge_select_q[g]
                         ? (pins_prev_q[g] && !i_wake_pins[g])
                         : (!pins_prev_q[g] && i_wake_pins[g]);
    end
  endgenerate

  // register writes and pending latch
  always_comb
  begin
    wake_line_enable_mask_d  = wake_line_enable_mask_q;
    wake_line_edge_select_d  = wake_line_edge_select_q;
    wake_line_pending_d      = wake_line_pending_q;
    wake_port_group_enable_d = wake_port_group_enable_q;
    global_irq_enable_d      = global_irq_enable_q;
    if (i_wr)
    begin
      unique case (i_addr)
        ADDR_WAKE_EN:   wake_line_enable_mask_d = i_wdata[N_LINES-1:0];
        ADDR_WAKE_EDGE: wake_line_edge_select_d = i_wdata[N_LINES-1:0];
        ADDR_WAKE_PEND: wake_line_pending_d     = i_wdata[N_LINES-1:0];
        ADDR_IRQ_CTRL:
        begin
          wake_port_group_enable_d = i_wdata[CTRL_GROUP_EN_BIT];
          global_irq_enable_d      = i_wdata[CTRL_GLOBAL_EN_BIT];
        end
      endcase
    end
    // edges latch whatever the enables say, and win over a clearing write
    wake_line_pending_d = wake_line_pending_d | edge_hit;
  end

  // wake port register bank
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wake_line_enable_mask_q  <= WAKE_EN_RST[N_LINES-1:0];
      wake_line_edge_select_q  <= WAKE_EDGE_RST[N_LINES-1:0];
      wake_line_pending_q      <= WAKE_PEND_RST[N_LINES-1:0];
      pins_prev_q              <= '0;
      wake_port_group_enable_q <= 1'b0;
      global_irq_enable_q      <= 1'b0;
    end
    else
    begin
      wake_line_enable_mask_q  <= wake_line_enable_mask_d;
      wake_line_edge_select_q  <= wake_line_edge_select_d;
      wake_line_pending_q      <= wake_line_pending_d;
      pins_prev_q              <= i_wake_pins;
      wake_port_group_enable_q <= wake_port_group_enable_d;
      global_irq_enable_q      <= global_irq_enable_d;
    end
  end

  // request, inhibit and wake decisions
  always_comb
  begin
    any_armed = |(wake_line_pending_q & wake_line_enable_mask_q);
    // all lines share one request and one vector
    wake_req  = any_armed && wake_port_group_enable_q && global_irq_enable_q;
    // pending trap locks out maskables; no nesting among maskables
    o_maskable_req = wake_req && !trap_pending_flag_q && !i_maskable_isr_active;
    // armed line ends halt; service only when the interrupt path is open
    o_wake         = i_halted && any_armed;
    o_wake_service = o_wake && wake_req;
  end

  // vector dispatch: low byte picked on the first dispatch cycle
  logic [7:0] vector_lo_q;
  logic [7:0] vector_lo_d;

  always_comb
  begin
    vector_lo_d = vector_lo_q;
    if (i_vector_dispatch_op)
    begin
      // trap ranks above everything, wake next, else default slot
      if (trap_pending_flag_q)
      begin
        vector_lo_d = VEC_LO_TRAP;
      end
      else if (wake_req)
      begin
        vector_lo_d = VEC_LO_WAKE;
      end
      else
      begin
        vector_lo_d = VEC_LO_DEFAULT;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      vector_lo_q <= VEC_LO_DEFAULT;
    end
    else
    begin
      vector_lo_q <= vector_lo_d;
    end
  end

  assign o_vector_lo = vector_lo_q;

  // read port: data one cycle after the strobe, zero otherwise
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb
  begin
    rdata_d = RDATA_RST;
    if (i_rd)
    begin
      unique case (i_addr)
        ADDR_WAKE_EN:   rdata_d[N_LINES-1:0] = wake_line_enable_mask_q;
        ADDR_WAKE_EDGE: rdata_d[N_LINES-1:0] = wake_line_edge_select_q;
        ADDR_WAKE_PEND: rdata_d[N_LINES-1:0] = wake_line_pending_q;
        ADDR_IRQ_CTRL:
        begin
          // trap pending is deliberately absent here
          rdata_d[CTRL_GROUP_EN_BIT]  = wake_port_group_enable_q;
          rdata_d[CTRL_GLOBAL_EN_BIT] = global_irq_enable_q;
          rdata_d[CTRL_WAKE_REQ_BIT]  = wake_req;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_q <= RDATA_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // checks
  a_trap_sets_pend: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    trap_event |=> trap_pending_flag_q && o_trap_raise)
    else $error("trap event did not set pending flag");

  a_clear_pend_op: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_clear_trap_pending_op && !trap_event) |=> !trap_pending_flag_q)
    else $error("clear op left pending flag set");

  a_pend_only_cleared: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (trap_pending_flag_q && !i_clear_trap_pending_op) |=> trap_pending_flag_q)
    else $error("pending flag dropped without clear op");

  a_zero_fetch_trap: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_fetch.valid && i_fetch.unmapped) |=> o_trap_raise && o_trap_return_pc == $past(i_fetch.pc))
    else $error("unmapped fetch did not trap at its address");

  a_overpop_trap: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_stack.pop && !i_stack.large_ram && i_stack.sp_after == 8'h30) |=> o_trap_raise)
    else $error("stack overpop did not trap");

  a_inhibit_maskable: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (trap_pending_flag_q || i_maskable_isr_active) |-> !o_maskable_req)
    else $error("maskable request while inhibited");

  a_vis_trap_vec: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_vector_dispatch_op && trap_pending_flag_q) |=> o_vector_lo == 8'hFE)
    else $error("trap vector not selected");

  a_vis_wake_vec: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_vector_dispatch_op && !trap_pending_flag_q) |=> o_vector_lo == (($past(wake_req)) ? 8'hE2 : 8'hE0))
    else $error("wrong dispatch vector");

  a_edge_latched: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (!wake_line_edge_select_q[0] && !pins_prev_q[0] && i_wake_pins[0]) |=> wake_line_pending_q[0])
    else $error("rising edge not latched");

  a_wake_gating: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_maskable_req |-> (wake_port_group_enable_q && global_irq_enable_q && any_armed))
    else $error("wake request without enables");

  a_trap_ungated: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (trap_event && !global_irq_enable_q) |=> o_trap_req)
    else $error("trap request gated by enables");

endmodule

`default_nettype wire

// ===== core_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural core sequencer: fetch, pop, clear and dispatch events
module core_seq_model
  import trap_wake_pkg::*;
(
  input  wire logic i_mclk,
  output var fetch_t     o_fetch,
  output var stack_pop_t o_stack,
  output logic           o_clear_trap_pending_op,
  output logic           o_vector_dispatch_op,
  output logic           o_maskable_isr_active,
  output logic           o_halted
);
  // all strobes idle at time zero
  initial
  begin
    o_fetch = '{1'b0, 1'b0, 15'h7fff, 8'hff};
    o_stack = '{1'b0, 8'hff, 1'b0};
    o_clear_trap_pending_op = 1'b0;
    o_vector_dispatch_op = 1'b0;
    o_maskable_isr_active = 1'b0;
    o_halted = 1'b0;
  end
  // one byte into the instruction register; bus then shows the inverse
  // so a stale opcode can never look like a fresh fetch
  task automatic fetch(input logic [14:0] pc, input logic [7:0] d, input logic unm);
    @(posedge i_mclk);
    o_fetch <= '{1'b1, unm, pc, d};
    @(posedge i_mclk);
    o_fetch <= '{1'b0, 1'b0, ~pc, ~d};
  endtask
  // one stack pop, large_ram held as a level afterwards
  task automatic pop(input logic [7:0] sp, input logic lg);
    @(posedge i_mclk);
    o_stack <= '{1'b1, sp, lg};
    @(posedge i_mclk);
    o_stack <= '{1'b0, ~sp, lg};
  endtask
  // clear-trap-pending instruction, one cycle
  task automatic clear_op();
    @(posedge i_mclk);
    o_clear_trap_pending_op <= 1'b1;
    @(posedge i_mclk);
    o_clear_trap_pending_op <= 1'b0;
  endtask
  // first cycle of the dispatch instruction
  task automatic dispatch();
    @(posedge i_mclk);
    o_vector_dispatch_op <= 1'b1;
    @(posedge i_mclk);
    o_vector_dispatch_op <= 1'b0;
  endtask
  // halt and maskable routine levels
  task automatic levels(input logic h, input logic isr);
    @(posedge i_mclk);
    o_halted <= h;
    o_maskable_isr_active <= isr;
  endtask
endmodule
`default_nettype wire

// ===== trap_and_wake_interrupt_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module trap_and_wake_interrupt_logic_tb;
  import trap_wake_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic [1:0]  i_addr = 2'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  i_wake_pins = 8'h00;
  logic [7:0]  o_rdata, o_fetch_opcode, o_vector_lo;
  logic [14:0] o_trap_return_pc;
  logic        o_trap_raise, o_trap_req, o_maskable_req, o_wake, o_wake_service;
  fetch_t      fetch;
  stack_pop_t  stack;
  logic        clr, disp, isr, halted;
  int          n_fail = 0;
  int          comparisons = 0;
  logic [7:0]  sp_tab [4] = '{8'h2f, 8'h30, 8'h6f, 8'h70};
  // 25 ns clock
  always #12.5 i_mclk = ~i_mclk;
  core_seq_model core (.i_mclk(i_mclk), .o_fetch(fetch), .o_stack(stack), .o_clear_trap_pending_op(clr),
    .o_vector_dispatch_op(disp), .o_maskable_isr_active(isr), .o_halted(halted));
  trap_wake_irq_ctrl uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fetch(fetch), .i_stack(stack),
    .i_clear_trap_pending_op(clr), .i_vector_dispatch_op(disp), .i_maskable_isr_active(isr),
    .i_halted(halted), .o_fetch_opcode(o_fetch_opcode), .o_trap_raise(o_trap_raise),
    .o_trap_return_pc(o_trap_return_pc), .o_trap_req(o_trap_req), .o_maskable_req(o_maskable_req),
    .o_vector_lo(o_vector_lo), .o_wake(o_wake), .o_wake_service(o_wake_service),
    .i_wake_pins(i_wake_pins));
  // compare and count
  task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // land after the edge's updates
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", e & m, o_rdata & m);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog, far beyond the hundred-odd cycles the tests need
  initial
  begin
    #100000;
    n_fail++;
    results();
  end
  initial
  begin
    repeat (8) @(posedge i_mclk);
    i_nrst <= 1'b1;
    step(0);
    chk("trap_req", 0, o_trap_req);
    chk("vector_lo", VEC_LO_DEFAULT, o_vector_lo);
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00, 8'hff);
    $display("test reset done");
    wr(ADDR_WAKE_EN, 8'hff);
    wr(ADDR_WAKE_EDGE, 8'h80);
    wr(ADDR_IRQ_CTRL, 8'h07);
    rd(ADDR_WAKE_EDGE, 8'h80, 8'hff);
    rd(ADDR_IRQ_CTRL, 8'h03, 8'h07);
    @(posedge i_mclk);
    i_wake_pins <= 8'h81;
    rd(ADDR_WAKE_PEND, 8'h01, 8'hff);
    chk("maskable_req", 1, o_maskable_req);
    @(posedge i_mclk);
    i_wake_pins <= 8'h01;
    rd(ADDR_WAKE_PEND, 8'h81, 8'hff);
    wr(ADDR_IRQ_CTRL, 8'h02);
    step(1);
    chk("maskable_req", 0, o_maskable_req);
    wr(ADDR_IRQ_CTRL, 8'h01);
    step(1);
    chk("maskable_req", 0, o_maskable_req);
    wr(ADDR_IRQ_CTRL, 8'h03);
    wr(ADDR_WAKE_EN, 8'h00);
    step(1);
    chk("maskable_req", 0, o_maskable_req);
    wr(ADDR_WAKE_EN, 8'h80);
    step(1);
    chk("maskable_req", 1, o_maskable_req);
    core.levels(1, 0);
    step(1);
    chk("wake_service", 1, o_wake_service);
    wr(ADDR_IRQ_CTRL, 8'h01);
    step(1);
    chk("wake", 1, o_wake);
    chk("wake_service", 0, o_wake_service);
    wr(ADDR_IRQ_CTRL, 8'h03);
    core.levels(0, 0);
    core.dispatch();
    step(0);
    chk("vector_lo", VEC_LO_WAKE, o_vector_lo);
    $display("test wake done");
    core.fetch(15'h0123, 8'h00, 1'b0);
    step(0);
    chk("trap_raise", 1, o_trap_raise);
    chk("trap_req", 1, o_trap_req);
    chk("return_pc", 15'h0123, o_trap_return_pc);
    chk("maskable_req", 0, o_maskable_req);
    step(1);
    chk("trap_raise", 0, o_trap_raise);
    rd(ADDR_IRQ_CTRL, 8'h03, 8'h03);
    core.levels(0, 1);
    core.dispatch();
    step(0);
    chk("vector_lo", VEC_LO_TRAP, o_vector_lo);
    core.levels(0, 0);
    core.clear_op();
    step(0);
    chk("trap_req", 0, o_trap_req);
    core.clear_op();
    step(0);
    chk("trap_req", 0, o_trap_req);
    chk("maskable_req", 1, o_maskable_req);
    core.levels(0, 1);
    step(0);
    chk("maskable_req", 0, o_maskable_req);
    core.levels(0, 0);
    core.fetch(15'h0200, 8'h5a, 1'b0);
    step(0);
    chk("trap_raise", 0, o_trap_raise);
    chk("fetch_opcode", 8'ha5, o_fetch_opcode);
    wr(ADDR_IRQ_CTRL, 8'h00);
    core.fetch(15'h7ffe, 8'h77, 1'b1);
    step(0);
    chk("trap_raise", 1, o_trap_raise);
    chk("return_pc", 15'h7ffe, o_trap_return_pc);
    rd(ADDR_IRQ_CTRL, 8'h00, 8'h03);
    core.clear_op();
    $display("test trap done");
    for (int k = 0; k < 4; k++)
    begin
      core.pop(sp_tab[k], k[1]);
      step(0);
      chk("overpop_raise", k[0], o_trap_raise);
      core.clear_op();
    end
    $display("test overpop done");
    wr(ADDR_IRQ_CTRL, 8'h03);
    wr(ADDR_WAKE_PEND, 8'h00);
    step(1);
    chk("maskable_req", 0, o_maskable_req);
    core.dispatch();
    step(0);
    chk("vector_lo", VEC_LO_DEFAULT, o_vector_lo);
    @(posedge i_mclk);
    i_wake_pins <= 8'h00;
    core.fetch(15'h0040, 8'h00, 1'b0);
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    step(2);
    chk("trap_req", 0, o_trap_req);
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(ADDR_WAKE_PEND, 8'h00, 8'hff);
    step(1);
    chk("trap_req", 0, o_trap_req);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
